// ---- shared/sdb_pkg.sv ----
// constants shared by dram device and controller
package sdb_pkg;
    // array organisation
    localparam int BANKS = 4;
    localparam int ROWS = 4096;
    localparam int COLS_X16 = 512;
    localparam int COLS_X8 = 1024;
    localparam int COLS_X4 = 2048;
    localparam int DQ_W = 16;
    localparam int ADDR_W = 12;
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int BANK_W = 2;
    localparam int MEM_AW = BANK_W + ROW_W + COL_W;
    localparam int MEM_WORDS = BANKS * ROWS * COLS_X16;

    // command codes {ras_b, cas_b, we_b}
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_LMR = 3'h0;

    // auto precharge / precharge-all flag
    localparam int AP_BIT = 10;

    // mode word layout
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BL_W = 3;
    localparam int MODE_BT_BIT = 3;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [11:0] MODE_RESET = 12'h000;
    localparam logic [11:0] CTL_MODE = 12'h000;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_RCD_NS = 20;
    localparam int T_RP_NS = 20;
    localparam int T_WR_NS = 20;
    localparam int T_RFC_NS = 70;
    localparam int REF_WINDOW_NS = 16_000_000;
    localparam int REF_ROWS = 4096;
    localparam int T_RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WR_CYC = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RFC_CYC = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_REFI_CYC = REF_WINDOW_NS / REF_ROWS / CLK_PERIOD_NS;
    localparam int READ_LAT_CYC = 2;
    localparam int CNT_W = 9;
endpackage

// ---- shared/sdb_if.sv ----
// dram pin bundle
`timescale 1ns/1ns
`default_nettype none
interface sdb_if;
    import sdb_pkg::*;
    logic cke;
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic bank_select_low;
    logic bank_select_high;
    logic [ADDR_W-1:0] row_column_address_lines;
    logic [DQ_W-1:0] dq_ctl_out;
    logic dq_ctl_oe;
    logic [DQ_W-1:0] dq_dev_out;
    logic dq_dev_oe;
    logic [DQ_W-1:0] dq;

    // undriven bus reads zero
    assign dq = dq_ctl_oe ? dq_ctl_out : (dq_dev_oe ? dq_dev_out : '0);

    modport device (
        input cke, cs_b, ras_b, cas_b, we_b,
        input bank_select_low, bank_select_high, row_column_address_lines,
        input dq,
        output dq_dev_out, dq_dev_oe
    );
    modport controller (
        output cke, cs_b, ras_b, cas_b, we_b,
        output bank_select_low, bank_select_high, row_column_address_lines,
        output dq_ctl_out, dq_ctl_oe,
        input dq
    );
endinterface
`default_nettype wire

// ---- design/sdb_device.sv ----
// four-bank synchronous dram device, x16 organisation
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// R1 - sample all pins on rising clock only
// R2 - four banks, 4096 rows, width-dependent columns (device models x16 only, 512 columns)
// R3 - controller activates row before read/write
// R4 - activate latches bank and row together
// R5 - read/write address is the start column
// R6 - burst 1,2,4,8 or page, stoppable
// R7 - burst steps column internally in order
// R8 - auto precharge closes row after burst
// R9 - new column command accepted every cycle
// R10 - precharge one bank while another bursts
// R11 - auto refresh and power-down supported
// R12 - extended temperature: no self refresh, 16ms
// R13 - precharge before activating another row
module sdb_device (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // link to the controller
    sdb_if.device pins,
    // status
    output logic [sdb_pkg::BANKS-1:0] bank_open,
    output logic burst_active,
    output logic powered_down,
    output logic refresh_pulse
);
    import sdb_pkg::*;

    // R2 x16 array
    logic [DQ_W-1:0] mem [0:MEM_WORDS-1];

    logic [BANKS-1:0] open_r, open_nxt;
    logic [ROW_W-1:0] row_r [0:BANKS-1];
    logic [ROW_W-1:0] row_nxt [0:BANKS-1];
    logic [ADDR_W-1:0] mode_r, mode_nxt;
    logic act_r, act_nxt;
    logic wr_r, wr_nxt;
    logic ap_r, ap_nxt;
    logic [BANK_W-1:0] bbank_r, bbank_nxt;
    logic [ROW_W-1:0] brow_r, brow_nxt;
    logic [COL_W-1:0] col_r, col_nxt;
    logic [COL_W-1:0] idx_r, idx_nxt;
    logic [DQ_W-1:0] dq_out_r, dq_out_nxt;
    logic dq_oe_r, dq_oe_nxt;
    logic pd_r, pd_nxt;
    logic ref_r, ref_nxt;

    logic [2:0] cmd;
    logic [BANK_W-1:0] cmd_bank;
    logic [ADDR_W-1:0] cmd_addr;
    logic [COL_W-1:0] mask;
    logic full_page;
    logic seq_order;
    logic last_beat;
    logic [COL_W-1:0] beat_col;
    logic [MEM_AW-1:0] cur_addr;
    logic mem_we;
    logic [MEM_AW-1:0] mem_wa;

    assign cmd = {pins.ras_b, pins.cas_b, pins.we_b};
    assign cmd_bank = {pins.bank_select_high, pins.bank_select_low};
    assign cmd_addr = pins.row_column_address_lines;

    // burst length as wrap mask
    always_comb begin
        case (mode_r[MODE_BL_LSB +: MODE_BL_W]) // R6
            BL_1: mask = 9'h000;
            BL_2: mask = 9'h001;
            BL_4: mask = 9'h003;
            BL_8: mask = 9'h007;
            default: mask = 9'h1FF;
        endcase
    end

    assign full_page = mode_r[MODE_BL_LSB +: MODE_BL_W] == BL_FULL;
    // page bursts are always sequential
    assign seq_order = !mode_r[MODE_BT_BIT] || full_page;
    assign last_beat = (idx_r == mask) && !full_page;

    // beat column wraps in its block
    always_comb begin
        if (seq_order) begin // R7
            beat_col = (col_r & ~mask) | (9'(col_r + idx_r) & mask);
        end else begin
            beat_col = (col_r & ~mask) | ((col_r ^ idx_r) & mask);
        end
    end

    assign cur_addr = {bbank_r, brow_r, beat_col};

    always_comb begin
        open_nxt = open_r;
        row_nxt = row_r;
        mode_nxt = mode_r;
        act_nxt = act_r;
        wr_nxt = wr_r;
        ap_nxt = ap_r;
        bbank_nxt = bbank_r;
        brow_nxt = brow_r;
        col_nxt = col_r;
        idx_nxt = idx_r;
        dq_out_nxt = dq_out_r;
        dq_oe_nxt = 1'b0;
        ref_nxt = 1'b0;
        mem_we = 1'b0;
        mem_wa = cur_addr;
        if (pins.cke) begin
            if (act_r) begin // R7
                if (wr_r) begin
                    mem_we = 1'b1;
                end else begin
                    dq_out_nxt = mem[cur_addr];
                    dq_oe_nxt = 1'b1;
                end
                idx_nxt = 9'(idx_r + 9'h001);
                if (last_beat) begin
                    act_nxt = 1'b0;
                    if (ap_r) begin
                        open_nxt[bbank_r] = 1'b0; // R8
                    end
                end
            end
            if (!pins.cs_b) begin
                case (cmd)
                    CMD_ACT: begin
                        open_nxt[cmd_bank] = 1'b1; // R4
                        row_nxt[cmd_bank] = cmd_addr; // R4
                    end
                    CMD_READ, CMD_WRITE: begin
                        // needs open row
                        if (open_r[cmd_bank]) begin // R3
                            // cut burst still closes row
                            if (act_r && ap_r && act_nxt) begin // R8
                                open_nxt[bbank_r] = 1'b0;
                            end
                            act_nxt = 1'b1; // R9
                            wr_nxt = cmd == CMD_WRITE;
                            ap_nxt = cmd_addr[AP_BIT];
                            bbank_nxt = cmd_bank;
                            brow_nxt = row_r[cmd_bank];
                            col_nxt = cmd_addr[COL_W-1:0]; // R5
                            idx_nxt = 9'h000;
                            if (cmd == CMD_WRITE) begin
                                // write beat 0 rides with command
                                dq_oe_nxt = 1'b0;
                                mem_we = 1'b1;
                                mem_wa = {cmd_bank, row_r[cmd_bank],
                                    cmd_addr[COL_W-1:0]};
                                idx_nxt = 9'h001;
                                if (mask == 9'h000) begin
                                    act_nxt = 1'b0;
                                    if (cmd_addr[AP_BIT]) begin
                                        open_nxt[cmd_bank] = 1'b0; // R8
                                    end
                                end
                            end
                        end
                    end
                    CMD_BST: begin
                        act_nxt = 1'b0; // R6
                    end
                    CMD_PRE: begin
                        if (cmd_addr[AP_BIT]) begin
                            open_nxt = '0;
                            act_nxt = 1'b0;
                        end else begin
                            open_nxt[cmd_bank] = 1'b0;
                            // other banks keep bursting
                            if (bbank_r == cmd_bank) begin // R10
                                act_nxt = 1'b0;
                            end
                        end
                    end
                    CMD_REF: begin
                        ref_nxt = 1'b1; // R11
                    end
                    CMD_LMR: begin
                        mode_nxt = cmd_addr;
                    end
                    default: begin
                    end
                endcase
            end
        end else begin
            // clock suspend freezes the burst
            dq_oe_nxt = dq_oe_r && act_r;
        end
        // no power-down mid-burst
        pd_nxt = !pins.cke && !act_r; // R11
    end

    always_ff @(posedge clock or negedge rst_b) begin // R1
        if (!rst_b) begin
            open_r <= '0;
            for (int b = 0; b < BANKS; b++) begin
                row_r[b] <= '0;
            end
            mode_r <= MODE_RESET;
            act_r <= 1'b0;
            wr_r <= 1'b0;
            ap_r <= 1'b0;
            bbank_r <= '0;
            brow_r <= '0;
            col_r <= '0;
            idx_r <= '0;
            dq_out_r <= '0;
            dq_oe_r <= 1'b0;
            pd_r <= 1'b0;
            ref_r <= 1'b0;
        end else begin
            open_r <= open_nxt;
            row_r <= row_nxt;
            mode_r <= mode_nxt;
            act_r <= act_nxt;
            wr_r <= wr_nxt;
            ap_r <= ap_nxt;
            bbank_r <= bbank_nxt;
            brow_r <= brow_nxt;
            col_r <= col_nxt;
            idx_r <= idx_nxt;
            dq_out_r <= dq_out_nxt;
            dq_oe_r <= dq_oe_nxt;
            pd_r <= pd_nxt;
            ref_r <= ref_nxt;
        end
    end

    // array not reset
    always_ff @(posedge clock) begin
        if (mem_we) begin
            mem[mem_wa] <= pins.dq; // R1
        end
    end

    assign pins.dq_dev_out = dq_out_r;
    assign pins.dq_dev_oe = dq_oe_r;
    assign bank_open = open_r;
    assign burst_active = act_r;
    assign powered_down = pd_r;
    assign refresh_pulse = ref_r;
endmodule
`default_nettype wire

// ---- design/sdb_controller.sv ----
// single-word dram controller
`timescale 1ns/1ns
`default_nettype none
module sdb_controller (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // link to the device
    sdb_if.controller pins,
    // user request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [sdb_pkg::BANK_W-1:0] req_bank,
    input wire logic [sdb_pkg::ROW_W-1:0] req_row,
    input wire logic [sdb_pkg::COL_W-1:0] req_col,
    input wire logic [sdb_pkg::DQ_W-1:0] req_wdata,
    output logic req_ready,
    // user answer
    output logic rsp_valid,
    output logic [sdb_pkg::DQ_W-1:0] rsp_rdata,
    // power and status
    input wire logic sleep,
    output logic init_done
);
    import sdb_pkg::*;

    typedef enum logic [3:0] {
        ST_INIT_PRE, ST_INIT_LMR, ST_INIT_WAIT, ST_IDLE, ST_ACT_WAIT,
        ST_DATA_WAIT, ST_RECOVER, ST_SLEEP
    } sdb_ctl_state_e;

    sdb_ctl_state_e state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CNT_W-1:0] refc_r, refc_nxt;
    logic ref_due_r, ref_due_nxt;
    logic cke_r, cke_nxt;
    logic [2:0] cmd_r, cmd_nxt;
    logic [BANK_W-1:0] bank_r, bank_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DQ_W-1:0] dq_out_r, dq_out_nxt;
    logic dq_oe_r, dq_oe_nxt;
    logic ready_r, ready_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic [DQ_W-1:0] rsp_data_r, rsp_data_nxt;
    logic init_r, init_nxt;
    logic wr_r, wr_nxt;
    logic [COL_W-1:0] col_r, col_nxt;
    logic [DQ_W-1:0] wdata_r, wdata_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        cke_nxt = cke_r;
        cmd_nxt = CMD_NOP;
        bank_nxt = bank_r;
        addr_nxt = addr_r;
        dq_out_nxt = dq_out_r;
        dq_oe_nxt = 1'b0;
        rsp_valid_nxt = 1'b0;
        rsp_data_nxt = rsp_data_r;
        init_nxt = init_r;
        wr_nxt = wr_r;
        col_nxt = col_r;
        wdata_nxt = wdata_r;
        ref_due_nxt = ref_due_r;
        // refresh tick
        if (refc_r == '0) begin
            refc_nxt = CNT_W'(T_REFI_CYC - 1); // R12
        end else begin
            refc_nxt = 9'(refc_r - 9'h001);
        end
        case (state_r)
            ST_INIT_PRE: begin
                cmd_nxt = CMD_PRE;
                addr_nxt = 12'h000;
                addr_nxt[AP_BIT] = 1'b1;
                cnt_nxt = CNT_W'(T_RP_CYC);
                state_nxt = ST_INIT_LMR;
            end
            ST_INIT_LMR: begin
                if (cnt_r == '0) begin
                    cmd_nxt = CMD_LMR;
                    addr_nxt = CTL_MODE;
                    cnt_nxt = CNT_W'(T_RP_CYC);
                    state_nxt = ST_INIT_WAIT;
                end else begin
                    cnt_nxt = 9'(cnt_r - 9'h001);
                end
            end
            ST_IDLE: begin
                if (ready_r && req_valid) begin
                    cmd_nxt = CMD_ACT; // R3
                    bank_nxt = req_bank; // R4
                    addr_nxt = req_row; // R4
                    wr_nxt = req_write;
                    col_nxt = req_col;
                    wdata_nxt = req_wdata;
                    cnt_nxt = CNT_W'(T_RCD_CYC - 1);
                    state_nxt = ST_ACT_WAIT;
                end else if (ref_due_r) begin
                    cmd_nxt = CMD_REF; // R12
                    ref_due_nxt = 1'b0;
                    cnt_nxt = CNT_W'(T_RFC_CYC - 1);
                    state_nxt = ST_RECOVER;
                end else if (sleep) begin
                    cke_nxt = 1'b0;
                    state_nxt = ST_SLEEP;
                end
            end
            ST_ACT_WAIT: begin
                if (cnt_r == '0) begin
                    cmd_nxt = wr_r ? CMD_WRITE : CMD_READ;
                    addr_nxt = 12'(col_r); // R5
                    // auto precharge: no row left open
                    addr_nxt[AP_BIT] = 1'b1; // R13
                    if (wr_r) begin
                        dq_oe_nxt = 1'b1;
                        dq_out_nxt = wdata_r;
                        cnt_nxt = CNT_W'(T_WR_CYC + T_RP_CYC - 1);
                        state_nxt = ST_RECOVER;
                    end else begin
                        cnt_nxt = CNT_W'(READ_LAT_CYC);
                        state_nxt = ST_DATA_WAIT;
                    end
                end else begin
                    cnt_nxt = 9'(cnt_r - 9'h001);
                end
            end
            ST_DATA_WAIT: begin
                if (cnt_r == '0) begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt = pins.dq;
                    cnt_nxt = CNT_W'(T_RP_CYC - 1); // R13
                    state_nxt = ST_RECOVER;
                end else begin
                    cnt_nxt = 9'(cnt_r - 9'h001);
                end
            end
            ST_SLEEP: begin
                // wake when sleep drops or refresh is due
                if (!sleep || ref_due_r) begin
                    cke_nxt = 1'b1;
                    cnt_nxt = 9'h000;
                    state_nxt = ST_RECOVER;
                end
            end
            default: begin
                if (cnt_r == '0) begin
                    init_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else begin
                    cnt_nxt = 9'(cnt_r - 9'h001);
                end
            end
        endcase
        // set wins over clear
        if (refc_r == '0) begin
            ref_due_nxt = 1'b1;
        end
        ready_nxt = state_nxt == ST_IDLE && !ref_due_nxt && !sleep;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_INIT_PRE;
            cnt_r <= '0;
            refc_r <= '0;
            ref_due_r <= 1'b0;
            cke_r <= 1'b1;
            cmd_r <= CMD_NOP;
            bank_r <= '0;
            addr_r <= '0;
            dq_out_r <= '0;
            dq_oe_r <= 1'b0;
            ready_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_data_r <= '0;
            init_r <= 1'b0;
            wr_r <= 1'b0;
            col_r <= '0;
            wdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            refc_r <= refc_nxt;
            ref_due_r <= ref_due_nxt;
            cke_r <= cke_nxt;
            cmd_r <= cmd_nxt;
            bank_r <= bank_nxt;
            addr_r <= addr_nxt;
            dq_out_r <= dq_out_nxt;
            dq_oe_r <= dq_oe_nxt;
            ready_r <= ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r <= rsp_data_nxt;
            init_r <= init_nxt;
            wr_r <= wr_nxt;
            col_r <= col_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    assign pins.cke = cke_r;
    assign pins.cs_b = 1'b0;
    assign pins.ras_b = cmd_r[2];
    assign pins.cas_b = cmd_r[1];
    assign pins.we_b = cmd_r[0];
    assign pins.bank_select_low = bank_r[0];
    assign pins.bank_select_high = bank_r[1];
    assign pins.row_column_address_lines = addr_r;
    assign pins.dq_ctl_out = dq_out_r;
    assign pins.dq_ctl_oe = dq_oe_r;
    assign req_ready = ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rsp_data_r;
    assign init_done = init_r;
endmodule
`default_nettype wire

// ---- verification/sdb_monitor.sv ----
// link assertions
`timescale 1ns/1ns
`default_nettype none
module sdb_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // link pins
    input wire logic cke,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [sdb_pkg::ADDR_W-1:0] row_column_address_lines,
    input wire logic dq_ctl_oe,
    input wire logic dq_dev_oe
);
    import sdb_pkg::*;
    logic [2:0] cmd;
    logic [1:0] bank;
    logic live;
    logic col;
    assign cmd = {ras_b, cas_b, we_b};
    assign bank = {bank_select_high, bank_select_low};
    assign live = cke && !cs_b;
    assign col = live && (cmd == CMD_READ || cmd == CMD_WRITE);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    no_contention_a: assert property (!(dq_ctl_oe && dq_dev_oe))
        else $error("bus clash");
    chip_select_a: assert property (cs_b == 1'b0)
        else $error("cs high");
    read_latency_a: assert property (live && cmd == CMD_READ
        |-> ##1 !dq_dev_oe ##1 dq_dev_oe ##1 !dq_dev_oe)
        else $error("read beat");
    act_first_a: assert property (col
        |-> $past(cmd, 2) == CMD_ACT && $past(bank, 2) == bank)
        else $error("no activate");
    act_to_column_a: assert property (live && cmd == CMD_ACT
        |-> ##1 cmd == CMD_NOP ##1 col && row_column_address_lines[AP_BIT])
        else $error("no ap access");
    write_data_a: assert property (live && cmd == CMD_WRITE
        |-> dq_ctl_oe ##1 !dq_ctl_oe)
        else $error("write data");
    mode_word_a: assert property (live && cmd == CMD_LMR
        |-> row_column_address_lines == CTL_MODE)
        else $error("mode word");
    refresh_gap_a: assert property (live && cmd == CMD_REF
        |=> (cmd == CMD_NOP) [*7])
        else $error("refresh gap");
    sleep_idle_a: assert property ($fell(cke)
        |-> !dq_dev_oe && !dq_ctl_oe)
        else $error("busy sleep");
    cover property (live && cmd == CMD_READ);
    cover property (live && cmd == CMD_WRITE);
    cover property (live && cmd == CMD_REF);
    cover property ($fell(cke));
endmodule
`default_nettype wire

// ---- verification/tb_sdram_bank_burst_access.sv ----
// bench: controller-device pair plus a driven device
`timescale 1ns/1ns
`default_nettype none
module tb_sdram_bank_burst_access;
    import sdb_pkg::*;
    logic clock = 0;
    logic rst_b = 0;
    logic req_valid = 0;
    logic req_write = 0;
    logic sleep = 0;
    logic [BANK_W-1:0] req_bank = '0;
    logic [ROW_W-1:0] req_row = '0;
    logic [COL_W-1:0] req_col = '0;
    logic [DQ_W-1:0] req_wdata = '0;
    logic req_ready, rsp_valid, init_done, burst1, burst2, pd1, pd2, rf1, rf2;
    logic [DQ_W-1:0] rsp_rdata;
    logic [BANKS-1:0] open1, open2;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int k;
    sdb_if ifc1 ();
    // bench-driven link
    sdb_if ifc2 ();
    sdb_controller sdb_controller_i (.clock(clock), .rst_b(rst_b),
        .pins(ifc1.controller), .req_valid(req_valid),
        .req_write(req_write), .req_bank(req_bank), .req_row(req_row),
        .req_col(req_col), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sleep(sleep),
        .init_done(init_done));
    sdb_device sdb_device_i (.clock(clock), .rst_b(rst_b),
        .pins(ifc1.device), .bank_open(open1), .burst_active(burst1),
        .powered_down(pd1), .refresh_pulse(rf1));
    sdb_device sdb_device_i2 (.clock(clock), .rst_b(rst_b),
        .pins(ifc2.device), .bank_open(open2), .burst_active(burst2),
        .powered_down(pd2), .refresh_pulse(rf2));
    sdb_monitor sdb_monitor_i (.clock(clock), .rst_b(rst_b),
        .cke(ifc1.cke), .cs_b(ifc1.cs_b), .ras_b(ifc1.ras_b),
        .cas_b(ifc1.cas_b), .we_b(ifc1.we_b),
        .bank_select_low(ifc1.bank_select_low),
        .bank_select_high(ifc1.bank_select_high),
        .row_column_address_lines(ifc1.row_column_address_lines),
        .dq_ctl_oe(ifc1.dq_ctl_oe), .dq_dev_oe(ifc1.dq_dev_oe));
    always #5 clock = ~clock;
    task automatic end_of_test;
        $display("cmp %0d fail %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic check_data(string what, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(string what, logic exp, logic got);
        check_data(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    function automatic logic [15:0] pat(logic [1:0] b, logic [8:0] c);
        return {b, 5'h15, c};
    endfunction
    task automatic user_op(bit w, logic [1:0] b, logic [11:0] r,
                           logic [8:0] c, logic [15:0] d);
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_bank <= b;
        req_row <= r;
        req_col <= c;
        req_wdata <= d;
        for (k = 0; k < 60; k++) begin
            @(posedge clock);
            if (req_ready === 1'b1) break;
        end
        req_valid <= 1'b0;
        if (!w) begin
            for (k = 0; k < 20; k++) begin
                @(posedge clock);
                if (rsp_valid === 1'b1) break;
            end
            check_bit("rsp", 1'b1, rsp_valid);
            check_data("read word", d, rsp_rdata);
        end
    endtask
    task automatic cmd(logic [2:0] c, logic [1:0] b, logic [11:0] a);
        @(posedge clock);
        {ifc2.ras_b, ifc2.cas_b, ifc2.we_b} <= c;
        {ifc2.bank_select_high, ifc2.bank_select_low} <= b;
        ifc2.row_column_address_lines <= a;
    endtask
    task automatic nop;
        cmd(CMD_NOP, 2'h0, 12'h000);
    endtask
    task automatic wr_burst(logic [1:0] b, logic [8:0] col, int n);
        for (int i = 0; i < n; i++) begin
            cmd(i == 0 ? CMD_WRITE : CMD_NOP, b, {3'h0, col});
            ifc2.dq_ctl_oe <= 1'b1;
            ifc2.dq_ctl_out <= pat(b, col + 9'(i));
        end
        nop();
        ifc2.dq_ctl_oe <= 1'b0;
    endtask
    task automatic rd_check(logic [1:0] b, logic [8:0] col, int n,
                            bit il, bit ap, bit pre1);
        logic [8:0] c;
        cmd(CMD_READ, b, {1'b0, ap, 1'b0, col});
        cmd(pre1 ? CMD_PRE : CMD_NOP, 2'h1, 12'h000);
        nop();
        for (int i = 0; i < n; i++) begin
            // wrap inside aligned block
            c = il ? col ^ 9'(i)
                : (col & ~9'(n - 1)) | ((col + 9'(i)) & 9'(n - 1));
            @(posedge clock);
            check_data("beat", pat(b, c), ifc2.dq_dev_out);
        end
        @(posedge clock);
        check_bit("end", 1'b0, ifc2.dq_dev_oe);
    endtask
    initial begin
        ifc2.cke = 1'b1;
        ifc2.cs_b = 1'b0;
        {ifc2.ras_b, ifc2.cas_b, ifc2.we_b} = CMD_NOP;
        {ifc2.bank_select_high, ifc2.bank_select_low} = 2'h0;
        ifc2.row_column_address_lines = '0;
        ifc2.dq_ctl_out = '0;
        ifc2.dq_ctl_oe = 1'b0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        user_op(1'b1, 2'h1, 12'hABC, 9'h1F0, 16'h5A3C);
        user_op(1'b1, 2'h3, 12'h001, 9'h000, 16'hC3A5);
        user_op(1'b0, 2'h1, 12'hABC, 9'h1F0, 16'h5A3C);
        user_op(1'b0, 2'h3, 12'h001, 9'h000, 16'hC3A5);
        cmd(CMD_ACT, 2'h2, 12'h005);
        cmd(CMD_ACT, 2'h1, 12'h7FF);
        cmd(CMD_LMR, 2'h0, {9'h000, BL_8});
        wr_burst(2'h2, 9'h008, 8);
        wr_burst(2'h1, 9'h008, 8);
        for (int i = 0; i < 4; i++) begin
            cmd(CMD_LMR, 2'h0, {9'h000, 3'(i)});
            rd_check(2'h2, 9'h00D, 1 << i, 1'b0, 1'b0, i == 2);
        end
        check_bit("bank1 shut", 1'b0, open2[1]);
        check_bit("bank2 open", 1'b1, open2[2]);
        cmd(CMD_READ, 2'h2, 12'h009);
        cmd(CMD_READ, 2'h2, 12'h00E);
        nop();
        @(posedge clock);
        check_data("pipelined 1", pat(2'h2, 9'h009), ifc2.dq_dev_out);
        @(posedge clock);
        check_data("pipelined 2", pat(2'h2, 9'h00E), ifc2.dq_dev_out);
        cmd(CMD_LMR, 2'h0, {8'h00, 1'b1, BL_8});
        rd_check(2'h2, 9'h00B, 8, 1'b1, 1'b1, 1'b0);
        check_bit("auto close", 1'b0, open2[2]);
        cmd(CMD_READ, 2'h2, 12'h00B);
        nop();
        repeat (2) @(posedge clock);
        check_bit("shut read", 1'b0, ifc2.dq_dev_oe);
        cmd(CMD_ACT, 2'h2, 12'h005);
        cmd(CMD_LMR, 2'h0, {9'h000, BL_FULL});
        cmd(CMD_READ, 2'h2, 12'h000);
        nop();
        repeat (20) @(posedge clock);
        check_bit("page", 1'b1, burst2);
        cmd(CMD_BST, 2'h0, 12'h000);
        nop();
        repeat (2) @(posedge clock);
        check_bit("stopped", 1'b0, burst2);
        check_bit("bst bus", 1'b0, ifc2.dq_dev_oe);
        cmd(CMD_REF, 2'h0, 12'h000);
        nop();
        k = 0;
        repeat (3) begin
            @(posedge clock);
            if (rf2 === 1'b1) k++;
        end
        check_data("ref pulses", 16'h0001, 16'(k));
        sleep <= 1'b1;
        repeat (6) @(posedge clock);
        check_bit("cke", 1'b0, ifc1.cke);
        check_bit("asleep", 1'b1, pd1);
        sleep <= 1'b0;
        repeat (6) @(posedge clock);
        check_bit("awake", 1'b0, pd1);
        user_op(1'b0, 2'h1, 12'hABC, 9'h1F0, 16'h5A3C);
        end_of_test();
    end
endmodule
`default_nettype wire
